// ---- alarm_source_and_clamp_control.sv ----
// Alarm source configuration register, hysteresis decode and clamp control
// How it works
// - Gate hysteresis code 00..11 gives 8, 16, 32, 64 LSBs.
// - Sense/temperature hysteresis code uses the same 8..64 LSB encoding.
// - Mode 00 holds gate clamped until mode rewritten; a clear command drops the clamp for one cycle only.
// - Mode 01 sets the alarm flag, never clamps.
// - Mode 10 clamps on alarm, releases on clean temp/sense conversion.
// - Mode 10 gate-voltage alarm latches the clamp through clean conversions until a clear command or mode write.
// - Mode 11 clamps and rewrites the mode field to 00.
// - Upper four written data bits are ignored.
// - D11 enables channel 2 gate-voltage alarms.
// - D10 picks windowing or hysteresis for channel 2 gate voltage.
// - D9 enables channel 2 temperature alarms.
// - D8 picks windowing or hysteresis for channel 2 temperature.
// - D7 enables channel 2 sense-voltage alarms.
// - D6 picks windowing or hysteresis for channel 2 sense voltage.
// - D5, D3, D1 enable channel 1 gate, temperature, sense alarms.
// - D4, D2, D0 pick comparison style for channel 1.
// - Gate hysteresis selector sits at hardware word D9..D8.
// - Sense/temperature hysteresis selector sits at hardware word D7..D6.
// - Clamp modes at hardware word D5..D4 (ch2), D3..D2 (ch1).
`timescale 1ns/100ps
module alarm_source_and_clamp_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [15:0] cmd_data,
    // Conversion results, one at a time
    input wire logic conv_valid,
    input wire logic conv_ch2,
    input wire logic conv_is_gate,
    input wire logic conv_is_temp,
    input wire logic conv_alarm,
    // Read answer
    output logic rd_valid,
    output logic [15:0] rd_data,
    // Comparator configuration
    output logic [6:0] gate_hyst_lsbs,
    output logic [6:0] sense_temp_hyst_lsbs,
    output logic [5:0] ch1_window_sel,
    output logic [5:0] ch2_window_sel,
    // Clamp and flags
    output logic ch1_gate_clamp,
    output logic ch2_gate_clamp,
    output logic [1:0] alarm_flags
);
    logic [11:0] alarm_source_config;
    logic [11:0] alarm_hw_config;
    logic src_wr;
    logic src_rd;
    logic hw_wr;
    logic hw_rd;
    logic clear_cmd;
    logic [1:0] ch1_clamp_mode;
    logic [1:0] ch2_clamp_mode;
    logic [1:0] gate_hyst_sel;
    logic [1:0] sense_temp_hyst_sel;
    logic [5:0] ch1_src;
    logic [5:0] ch2_src;
    logic ch1_force_hold;
    logic ch2_force_hold;
    logic ch1_clamp_int;
    logic ch2_clamp_int;
    logic [1:0] flags_int;

    assign src_wr = cmd_valid && cmd_byte == alarm_cfg_pkg::cmd_src_cfg_write;
    assign src_rd = cmd_valid && cmd_byte == alarm_cfg_pkg::cmd_src_cfg_read;
    assign hw_wr = cmd_valid && cmd_byte == alarm_cfg_pkg::cmd_hw_cfg_write;
    assign hw_rd = cmd_valid && cmd_byte == alarm_cfg_pkg::cmd_hw_cfg_read;
    assign clear_cmd = cmd_valid && cmd_byte == alarm_cfg_pkg::cmd_clear_clamp;

    // Source register keeps only the low twelve bits
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_source_config <= alarm_cfg_pkg::src_cfg_reset;
        end else if (src_wr) begin
            alarm_source_config <= cmd_data[11:0];
        end
    end

    // Hardware word; a semi-automatic alarm overrides a same-cycle write
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_hw_config <= alarm_cfg_pkg::hw_cfg_reset;
        end else begin
            if (hw_wr) begin
                alarm_hw_config <= cmd_data[11:0];
            end
            if (ch1_force_hold) begin
                alarm_hw_config[alarm_cfg_pkg::ch1_clamp_lo_pos +: 2] <=
                    alarm_cfg_pkg::clamp_hold;
            end
            if (ch2_force_hold) begin
                alarm_hw_config[alarm_cfg_pkg::ch2_clamp_lo_pos +: 2] <=
                    alarm_cfg_pkg::clamp_hold;
            end
        end
    end

    assign gate_hyst_sel = alarm_hw_config[alarm_cfg_pkg::gate_hyst_lo_pos +: 2];
    assign sense_temp_hyst_sel =
        alarm_hw_config[alarm_cfg_pkg::sense_temp_hyst_lo_pos +: 2];
    assign ch1_clamp_mode = alarm_hw_config[alarm_cfg_pkg::ch1_clamp_lo_pos +: 2];
    assign ch2_clamp_mode = alarm_hw_config[alarm_cfg_pkg::ch2_clamp_lo_pos +: 2];
    assign ch1_src = alarm_source_config[5:0];
    assign ch2_src =
        alarm_source_config[alarm_cfg_pkg::ch2_base +: 6];

    function automatic logic [6:0] hyst_decode(input logic [1:0] sel);
        unique case (sel)
            2'h0: hyst_decode = alarm_cfg_pkg::hyst_8;
            2'h1: hyst_decode = alarm_cfg_pkg::hyst_16;
            2'h2: hyst_decode = alarm_cfg_pkg::hyst_32;
            2'h3: hyst_decode = alarm_cfg_pkg::hyst_64;
        endcase
    endfunction

    // Registered decode keeps outputs glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_hyst_lsbs <= alarm_cfg_pkg::hyst_8;
            sense_temp_hyst_lsbs <= alarm_cfg_pkg::hyst_8;
        end else begin
            gate_hyst_lsbs <= hyst_decode(gate_hyst_sel);
            sense_temp_hyst_lsbs <= hyst_decode(sense_temp_hyst_sel);
        end
    end

    // Copy of each channel's six source bits: window picks and enables interleaved
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_window_sel <= 6'h00;
            ch2_window_sel <= 6'h00;
        end else begin
            ch1_window_sel <= ch1_src;
            ch2_window_sel <= ch2_src;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= src_rd || hw_rd;
            if (src_rd) begin
                rd_data <= {4'h0, alarm_source_config};
            end else if (hw_rd) begin
                rd_data <= {4'h0, alarm_hw_config};
            end
        end
    end

    clamp_channel u_ch1 (
        .clk(clk),
        .rst(rst),
        .clamp_mode(ch1_clamp_mode),
        .gate_en(ch1_src[alarm_cfg_pkg::gate_en_pos]),
        .temp_en(ch1_src[alarm_cfg_pkg::temp_en_pos]),
        .sense_en(ch1_src[alarm_cfg_pkg::sense_en_pos]),
        .conv_valid(conv_valid && !conv_ch2),
        .conv_is_gate(conv_is_gate),
        .conv_is_temp(conv_is_temp),
        .conv_alarm(conv_alarm),
        .clear_cmd(clear_cmd),
        .mode_written(hw_wr),
        .gate_clamp(ch1_clamp_int),
        .alarm_flag(flags_int[0]),
        .force_hold(ch1_force_hold)
    );

    clamp_channel u_ch2 (
        .clk(clk),
        .rst(rst),
        .clamp_mode(ch2_clamp_mode),
        .gate_en(ch2_src[alarm_cfg_pkg::gate_en_pos]),
        .temp_en(ch2_src[alarm_cfg_pkg::temp_en_pos]),
        .sense_en(ch2_src[alarm_cfg_pkg::sense_en_pos]),
        .conv_valid(conv_valid && conv_ch2),
        .conv_is_gate(conv_is_gate),
        .conv_is_temp(conv_is_temp),
        .conv_alarm(conv_alarm),
        .clear_cmd(clear_cmd),
        .mode_written(hw_wr),
        .gate_clamp(ch2_clamp_int),
        .alarm_flag(flags_int[1]),
        .force_hold(ch2_force_hold)
    );

    assign ch1_gate_clamp = ch1_clamp_int;
    assign ch2_gate_clamp = ch2_clamp_int;
    assign alarm_flags = flags_int;
endmodule

// ---- alarm_cfg_pkg.sv ----
// Shared constants for the alarm source and clamp control block
package alarm_cfg_pkg;
    // Command bytes
    localparam logic [7:0] cmd_hw_cfg_write = 8'h3c;
    localparam logic [7:0] cmd_hw_cfg_read = 8'hbc;
    localparam logic [7:0] cmd_src_cfg_write = 8'h3e;
    localparam logic [7:0] cmd_src_cfg_read = 8'hbe;
    localparam logic [7:0] cmd_clear_clamp = 8'h5a;
    // Register widths and reset values
    localparam int word_w = 16;
    localparam int cfg_w = 12;
    localparam logic [11:0] src_cfg_reset = 12'h000;
    localparam logic [11:0] hw_cfg_reset = 12'h000;
    // Source register fields, per-channel base: ch1 at 0, ch2 at 6
    localparam int ch2_base = 6;
    localparam int sense_win_pos = 0;
    localparam int sense_en_pos = 1;
    localparam int temp_win_pos = 2;
    localparam int temp_en_pos = 3;
    localparam int gate_win_pos = 4;
    localparam int gate_en_pos = 5;
    // Hardware register fields
    localparam int gate_hyst_lo_pos = 8;
    localparam int sense_temp_hyst_lo_pos = 6;
    localparam int ch2_clamp_lo_pos = 4;
    localparam int ch1_clamp_lo_pos = 2;
    // Clamp modes
    localparam logic [1:0] clamp_hold = 2'h0;
    localparam logic [1:0] clamp_flag_only = 2'h1;
    localparam logic [1:0] clamp_auto = 2'h2;
    localparam logic [1:0] clamp_semi = 2'h3;
    // Hysteresis sizes in LSBs
    localparam logic [6:0] hyst_8 = 7'h08;
    localparam logic [6:0] hyst_16 = 7'h10;
    localparam logic [6:0] hyst_32 = 7'h20;
    localparam logic [6:0] hyst_64 = 7'h40;
endpackage

// ---- clamp_channel.sv ----
// One channel of alarm flag and gate clamp control
`timescale 1ns/100ps
module clamp_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] clamp_mode,
    input wire logic gate_en,
    input wire logic temp_en,
    input wire logic sense_en,
    // Conversion results
    input wire logic conv_valid,
    input wire logic conv_is_gate,
    input wire logic conv_is_temp,
    input wire logic conv_alarm,
    input wire logic clear_cmd,
    input wire logic mode_written,
    // Results
    output logic gate_clamp,
    output logic alarm_flag,
    output logic force_hold
);
    logic enabled;
    logic latched;
    logic evaluate;

    assign enabled = conv_is_gate ? gate_en : (conv_is_temp ? temp_en : sense_en);
    assign evaluate = conv_valid && enabled;

    // Flag set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_flag <= 1'b0;
        end else if (evaluate && conv_alarm) begin
            alarm_flag <= 1'b1;
        end else if (clear_cmd) begin
            alarm_flag <= 1'b0;
        end
    end

    // Latched clamp in mode 10 after a gate alarm; a same-cycle set beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            latched <= 1'b0;
        end else if (evaluate && conv_alarm && conv_is_gate
                && clamp_mode == alarm_cfg_pkg::clamp_auto) begin
            latched <= 1'b1;
        end else if (mode_written || clear_cmd) begin
            latched <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_clamp <= 1'b0;
        end else begin
            unique case (clamp_mode)
                alarm_cfg_pkg::clamp_hold: begin
                    gate_clamp <= !clear_cmd;
                end
                alarm_cfg_pkg::clamp_flag_only: begin
                    gate_clamp <= 1'b0;
                end
                alarm_cfg_pkg::clamp_auto: begin
                    if (evaluate && !conv_is_gate) begin
                        gate_clamp <= conv_alarm || latched;
                    end else if (evaluate && conv_alarm) begin
                        gate_clamp <= 1'b1;
                    end
                end
                alarm_cfg_pkg::clamp_semi: begin
                    if (evaluate && conv_alarm) begin
                        gate_clamp <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Semi-automatic alarm asks for the mode field to drop to 00
    assign force_hold = evaluate && conv_alarm
        && clamp_mode == alarm_cfg_pkg::clamp_semi;
endmodule

// ---- alarm_cfg_checker_assertions.sv ----
// Port assertions for the alarm source and clamp block
`timescale 1ns/100ps
module alarm_cfg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [15:0] cmd_data,
    // Outputs
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic [6:0] gate_hyst_lsbs,
    input wire logic [6:0] sense_temp_hyst_lsbs,
    input wire logic [5:0] ch1_window_sel,
    input wire logic [5:0] ch2_window_sel,
    input wire logic ch1_gate_clamp,
    input wire logic ch2_gate_clamp,
    input wire logic [1:0] alarm_flags
);
    wire logic rd_cmd = cmd_valid && (cmd_byte == 8'hbe || cmd_byte == 8'hbc);
    wire logic src_wr = cmd_valid && cmd_byte == 8'h3e;
    wire logic hw_wr = cmd_valid && cmd_byte == 8'h3c;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Reset itself is the cause here, so it must not disable the check
    property p_reset; disable iff (1'b0)
        rst |=> alarm_flags == 2'h0 && !rd_valid && rd_data == 16'h0000 && !ch1_gate_clamp;
    endproperty
    a_reset: assert property (p_reset) else $error("state after reset");
    property p_rd_ans; rd_cmd |=> rd_valid && rd_data[15:12] == 4'h0; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer");
    property p_rd_hold; !rd_cmd |=> !rd_valid && $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_win1; src_wr |-> ##2 ch1_window_sel == $past(cmd_data[5:0], 2); endproperty
    a_win1: assert property (p_win1) else $error("ch1 window bits");
    property p_win2; src_wr |-> ##2 ch2_window_sel == $past(cmd_data[11:6], 2); endproperty
    a_win2: assert property (p_win2) else $error("ch2 window bits");
    property p_hg; hw_wr |-> ##2 gate_hyst_lsbs == 7'h08 << $past(cmd_data[9:8], 2); endproperty
    a_hg: assert property (p_hg) else $error("gate hysteresis");
    property p_hs;
        hw_wr |-> ##2 sense_temp_hyst_lsbs == 7'h08 << $past(cmd_data[7:6], 2);
    endproperty
    a_hs: assert property (p_hs) else $error("sense hysteresis");
    property p_boot; $fell(rst) |=> ch1_gate_clamp && ch2_gate_clamp; endproperty
    a_boot: assert property (p_boot) else $error("default clamp");
endmodule
bind alarm_source_and_clamp_control alarm_cfg_checker chk (.clk, .rst, .cmd_valid, .cmd_byte,
    .cmd_data, .rd_valid, .rd_data, .gate_hyst_lsbs, .sense_temp_hyst_lsbs, .ch1_window_sel,
    .ch2_window_sel, .ch1_gate_clamp, .ch2_gate_clamp, .alarm_flags);

// ---- host_model.sv ----
// Host model sending one-cycle command bytes with data
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic clk,
    // Command port
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic [15:0] cmd_data,
    // Read answer
    input wire logic rd_valid,
    input wire logic [15:0] rd_data
);
    initial {cmd_valid, cmd_byte, cmd_data} = 25'h000_0000;
    // Released lines show inverted leftovers so stale values never match
    task automatic send(input logic [7:0] b, input logic [15:0] d, output logic [16:0] ans);
        @(negedge clk);
        {cmd_valid, cmd_byte, cmd_data} = {1'b1, b, d};
        @(negedge clk);
        ans = {rd_valid, rd_data};
        {cmd_valid, cmd_byte, cmd_data} = {1'b0, ~b, ~d};
    endtask
endmodule

// ---- test_alarm_source_and_clamp_control.sv ----
// Self-checking bench for the alarm source and clamp block
`timescale 1ns/100ps
module test_alarm_source_and_clamp_control;
    logic clk, rst, cmd_valid, rd_valid, ch1_gate_clamp, ch2_gate_clamp;
    logic conv_valid, conv_ch2, conv_is_gate, conv_is_temp, conv_alarm;
    logic [7:0] cmd_byte;
    logic [15:0] cmd_data, rd_data;
    logic [6:0] gate_hyst_lsbs, sense_temp_hyst_lsbs;
    logic [5:0] ch1_window_sel, ch2_window_sel;
    logic [1:0] alarm_flags;
    logic [16:0] ans, bit_i;
    int err_total = 0;
    int checks_done = 0;
    host_model host (.clk, .cmd_valid, .cmd_byte, .cmd_data, .rd_valid, .rd_data);
    alarm_source_and_clamp_control DUT (.clk, .rst, .cmd_valid, .cmd_byte, .cmd_data,
        .conv_valid, .conv_ch2, .conv_is_gate, .conv_is_temp, .conv_alarm, .rd_valid,
        .rd_data, .gate_hyst_lsbs, .sense_temp_hyst_lsbs, .ch1_window_sel, .ch2_window_sel,
        .ch1_gate_clamp, .ch2_gate_clamp, .alarm_flags);
    always #50 clk = ~clk;
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Kind is {ch2, gate, temp, alarm}; result is settled by the next falling edge
    task automatic conv(input logic [3:0] kind);
        @(negedge clk);
        {conv_valid, conv_ch2, conv_is_gate, conv_is_temp, conv_alarm} = {1'b1, kind};
        @(negedge clk);
        conv_valid = 1'b0;
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
    initial begin
        {clk, rst, conv_valid, conv_ch2, conv_is_gate, conv_is_temp, conv_alarm} = 7'h20;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({ch1_gate_clamp, ch2_gate_clamp}, 17'h0_0003);
        for (int i = 0; i < 12; i++) begin
            bit_i = 17'h0_0001 << i;
            host.send(8'h3e, 16'hf000 | bit_i[15:0], ans);
            host.send(8'hbe, 16'h0000, ans);
            check(ans, 17'h1_0000 | bit_i);
            check({ch2_window_sel, ch1_window_sel}, bit_i);
        end
        for (int c = 0; c < 4; c++) begin
            host.send(8'h3c, {6'h00, c[1:0], ~c[1:0], 6'h14}, ans);
            @(negedge clk);
            check(gate_hyst_lsbs, 17'h0_0008 << c);
            check(sense_temp_hyst_lsbs, 17'h0_0008 << (3 - c));
        end
        host.send(8'h3e, 16'h0fff, ans);
        conv(4'b0011);
        check({alarm_flags, ch1_gate_clamp, ch2_gate_clamp}, 17'h0_0004);
        host.send(8'h5a, 16'h0000, ans);
        host.send(8'h3c, 16'h0024, ans);
        host.send(8'h3e, 16'h0000, ans);
        conv(4'b1101);
        check({alarm_flags, ch2_gate_clamp}, 17'h0_0000);
        host.send(8'h3e, 16'h0fff, ans);
        conv(4'b1011);
        check({ch1_gate_clamp, ch2_gate_clamp}, 17'h0_0001);
        conv(4'b1000);
        check(ch2_gate_clamp, 17'h0_0000);
        conv(4'b1101);
        conv(4'b1010);
        check({alarm_flags, ch2_gate_clamp}, 17'h0_0005);
        host.send(8'h3c, 16'h002c, ans);
        conv(4'b0001);
        host.send(8'hbc, 16'h0000, ans);
        check(ans, 17'h1_0020);
        conv(4'b0000);
        check(ch1_gate_clamp, 17'h0_0001);
        host.send(8'h3c, 16'h0024, ans);
        @(negedge clk);
        check(ch1_gate_clamp, 17'h0_0000);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        host.send(8'hbe, 16'h0000, ans);
        check(ans, 17'h1_0000);
        check({alarm_flags, ch1_gate_clamp, ch2_gate_clamp}, 17'h0_0003);
        host.send(8'h5a, 16'h0000, ans);
        check({ch1_gate_clamp, ch2_gate_clamp}, 17'h0_0000);
        end_of_test();
    end
endmodule
